// ===== core/aar_ack_timer.v
// Purpose: Acknowledgement start delay counted in symbol periods.
// Assumes: symbolTick is a one-cycle pulse once per symbol period.
// Notes: In slotted operation the host edge starts the acknowledgement.
`timescale 1ns/10ps
`include "aar_defines.vh"

module aar_ack_timer (
    input wire clk_sys,
    input wire rst,
    input wire start,
    input wire shortDelay,
    input wire slotted,
    input wire symbolTick,
    input wire trigger,
    output reg ackGo,
    output reg waitTrigger,
    output reg active
);

    reg [3:0] symCount;
    reg [3:0] target;

    always @* begin
        if (slotted) begin
            target = `AAR_ACK_SYMS_SLOTTED; // R10
        end else if (shortDelay) begin
            target = `AAR_ACK_SYMS_SHORT; // R9
        end else begin
            target = `AAR_ACK_SYMS_LONG; // R9
        end
    end

    // ============================================================
    // Counter from the last received symbol
    always @(posedge clk_sys) begin
        if (rst) begin
            symCount <= 4'h0;
            ackGo <= 1'b0;
            waitTrigger <= 1'b0;
            active <= 1'b0;
        end else begin
            ackGo <= 1'b0;
            if (start) begin
                symCount <= 4'h0; // R24
                active <= 1'b1;
                waitTrigger <= 1'b0;
            end else if (active && !waitTrigger) begin
                if (symbolTick) begin
                    symCount <= symCount + 4'h1; // R24
                    if (symCount + 4'h1 >= target) begin
                        if (slotted) begin
                            waitTrigger <= 1'b1; // R23
                        end else begin
                            ackGo <= 1'b1;
                            active <= 1'b0;
                        end
                    end
                end
            end else if (waitTrigger && trigger) begin
                // Edge before the earliest slot is simply ignored
                ackGo <= 1'b1; // R23
                waitTrigger <= 1'b0;
                active <= 1'b0;
            end
        end
    end

endmodule

// ===== core/aar_defines.vh
// Purpose: Shared constants for the auto-ack receive extension block.
// Assumes: Byte-wide register port with 6-bit register addresses.
// Notes: All offsets, fields, reset values and counts live here.
`ifndef AAR_DEFINES_VH
`define AAR_DEFINES_VH

// ============================================================
// Register offsets
`define AAR_OFS_RX_STATUS 6'h06
`define AAR_OFS_PROTECT 6'h0C
`define AAR_OFS_EXT_RX 6'h17
`define AAR_OFS_EXT_OP 6'h2C
`define AAR_OFS_ACK_POLICY 6'h2E

// ============================================================
// Field positions
`define AAR_BIT_CRC_VALID 7
`define AAR_BIT_PROTECT_EN 7
`define AAR_BIT_PROMISCUOUS 1
`define AAR_BIT_ACK_DELAY_SEL 2
`define AAR_BIT_RES_UPLOAD 4
`define AAR_BIT_RES_FILTER 5
`define AAR_BIT_SLOTTED 0
`define AAR_BIT_COORD 3
`define AAR_BIT_ACK_DISABLE 4
`define AAR_FLD_VERSION_HI 7
`define AAR_FLD_VERSION_LO 6

// ============================================================
// Reset values
`define AAR_RST_PROTECT 8'h00
`define AAR_RST_EXT_RX 8'h00
`define AAR_RST_EXT_OP 8'h00
`define AAR_RST_ACK_POLICY 8'h00
`define AAR_RD_UNMAPPED 8'h00

// ============================================================
// Frame type coding: values with the top bit set are reserved
`define AAR_FTYPE_RESERVED_BIT 2

// ============================================================
// Timing, in symbol periods and clock cycles
`define AAR_ACK_SYMS_LONG 4'h0C
`define AAR_ACK_SYMS_SHORT 4'h2
`define AAR_ACK_SYMS_SLOTTED 4'h6
`define AAR_CLK_OFF_CYCLES 6'h23

`endif

// ===== core/aar_receive_ctrl.v
// Purpose: Receive-side control of the auto-ack receive mode.
// Assumes: Frame parser and filter supply per-frame verdict pulses.
// Notes: Clock output gating for the clockless listening state.
// Summary of operation
// R1: Sniffer setup signals every frame with receive-start and frame-end; reserved frame types still follow R5-R8 for frame-end.
// R2: Checksum-valid status bit updated at every frame end.
// R3: Host reads checksum-valid after frame-end and drops failed frames.
// R4: Reserved-type upload bit 4, filter bit 5 of extended receive control.
// R5: Upload without filter: frame-end for good reserved frames, no match.
// R6: Upload with filter: reserved frames filtered like data frames.
// R7: Filtered reserved: frame-end on match and good check; ack if asked.
// R8: Upload cleared: reserved frame types silently discarded.
// R9: Ack delay bit selects 12 or 2 symbol periods.
// R10: Slotted operation: ack trigger no earlier than 6 symbols.
// R11: Frame-protection enable at bit 7 of register 0x0C.
// R12: Coordinator-role bit at bit 3 of register 0x2E.
// R13: Version policy field limits acknowledgement by frame version.
// R14: Ack-disable bit suppresses acknowledgement frames.
// R15: Pin rising edge in listen state enters clockless listening.
// R16: Clockless state left on valid frame or pin falling edge.
// R17: Clock output off 35 cycles after edge, at once at slow rates.
// R18: Valid frame in clockless state raises frame-end, restores clock.
// R19: Requested ack enters busy state, then returns to listen.
// R20: Clockless state re-entered only on a new rising edge.
// R21: Host should not use clockless listening during slotted operation.
// R22: Address-match only on third-level filter pass.
// R23: Slotted ack waits for a host rising edge on the pin.
// R24: Ack delay counted from the last received symbol.
`timescale 1ns/10ps
`include "aar_defines.vh"

module aar_receive_ctrl (
    input wire clk_sys,
    input wire rst,
    input wire [5:0] regAddr,
    input wire regWrEn,
    input wire [7:0] regWrData,
    output reg [7:0] regRdData,
    input wire sleepTransmitPin,
    input wire rxFrameStart,
    input wire rxFrameDone,
    input wire [2:0] rxFrameType,
    input wire [1:0] rxFrameVersion,
    input wire rxAckRequest,
    input wire rxFcsOk,
    input wire rxAddrPass,
    input wire symbolTick,
    input wire clkRateSlow,
    input wire ackTxDone,
    output reg rxStartEvent,
    output reg frameEndEvent,
    output reg addressMatchEvent,
    output wire ackTxStart,
    output wire ackWaitTrigger,
    output reg hostClockOutEn,
    output reg [1:0] trxState,
    output wire promiscuousEnable,
    output wire frameProtectEn,
    output wire coordinatorRole
);

    // ============================================================
    // Register file
    reg [7:0] protectCtrl;
    reg [7:0] extRxCtrl;
    reg [7:0] extOpCtrl;
    reg [7:0] ackPolicyCtrl;
    reg crcValid;

    wire reservedUpload;
    wire reservedFilter;
    wire ackDelaySelect;
    wire slottedOp;
    wire ackDisable;
    wire [1:0] versionAckPolicy;

    assign frameProtectEn = protectCtrl[`AAR_BIT_PROTECT_EN]; // R11
    assign promiscuousEnable = extRxCtrl[`AAR_BIT_PROMISCUOUS];
    assign ackDelaySelect = extRxCtrl[`AAR_BIT_ACK_DELAY_SEL]; // R9
    assign reservedUpload = extRxCtrl[`AAR_BIT_RES_UPLOAD]; // R4
    assign reservedFilter = extRxCtrl[`AAR_BIT_RES_FILTER]; // R4
    assign slottedOp = extOpCtrl[`AAR_BIT_SLOTTED];
    assign coordinatorRole = ackPolicyCtrl[`AAR_BIT_COORD]; // R12
    assign ackDisable = ackPolicyCtrl[`AAR_BIT_ACK_DISABLE];
    assign versionAckPolicy =
        ackPolicyCtrl[`AAR_FLD_VERSION_HI:`AAR_FLD_VERSION_LO];

    always @(posedge clk_sys) begin
        if (rst) begin
            protectCtrl <= `AAR_RST_PROTECT;
            extRxCtrl <= `AAR_RST_EXT_RX;
            extOpCtrl <= `AAR_RST_EXT_OP;
            ackPolicyCtrl <= `AAR_RST_ACK_POLICY;
        end else if (regWrEn) begin
            case (regAddr)
                `AAR_OFS_PROTECT: begin
                    protectCtrl <= regWrData;
                end
                `AAR_OFS_EXT_RX: begin
                    extRxCtrl <= regWrData;
                end
                `AAR_OFS_EXT_OP: begin
                    extOpCtrl <= regWrData;
                end
                `AAR_OFS_ACK_POLICY: begin
                    ackPolicyCtrl <= regWrData;
                end
                default: begin
                end
            endcase
        end
    end

    // Read data follows the address one cycle later
    always @(posedge clk_sys) begin
        if (rst) begin
            regRdData <= `AAR_RD_UNMAPPED;
        end else begin
            case (regAddr)
                `AAR_OFS_RX_STATUS: begin
                    regRdData <= {crcValid, 7'h00};
                end
                `AAR_OFS_PROTECT: begin
                    regRdData <= protectCtrl;
                end
                `AAR_OFS_EXT_RX: begin
                    regRdData <= extRxCtrl;
                end
                `AAR_OFS_EXT_OP: begin
                    regRdData <= extOpCtrl;
                end
                `AAR_OFS_ACK_POLICY: begin
                    regRdData <= ackPolicyCtrl;
                end
                default: begin
                    regRdData <= `AAR_RD_UNMAPPED;
                end
            endcase
        end
    end

    // ============================================================
    // Frame verdict
    function versionAcked;
        input [1:0] policy;
        input [1:0] version;
        begin
            case (policy)
                2'h0: versionAcked = (version == 2'h0); // R13
                2'h1: versionAcked = (version <= 2'h1); // R13
                2'h2: versionAcked = (version <= 2'h2); // R13
                default: versionAcked = 1'b1; // R13
            endcase
        end
    endfunction

    reg next_frameEnd;
    reg next_addrMatch;
    reg next_ackWanted;
    wire isReserved;
    wire ackAllowed;

    assign isReserved = rxFrameType[`AAR_FTYPE_RESERVED_BIT];
    // Version policy and disable gate every acknowledgement
    assign ackAllowed = !ackDisable && // R14
        versionAcked(versionAckPolicy, rxFrameVersion); // R13

    always @* begin
        next_frameEnd = 1'b0;
        next_addrMatch = 1'b0;
        next_ackWanted = 1'b0;
        if (isReserved) begin
            if (!reservedUpload) begin
                next_frameEnd = 1'b0; // R8
            end else if (!reservedFilter) begin
                next_frameEnd = rxFcsOk; // R5
                next_addrMatch = 1'b0; // R5
                next_ackWanted = 1'b0; // R5
            end else begin
                next_addrMatch = rxAddrPass; // R6
                next_frameEnd = rxAddrPass && rxFcsOk; // R7
                next_ackWanted = rxAddrPass && rxFcsOk &&
                    rxAckRequest && ackAllowed; // R7
            end
        end else begin
            next_addrMatch = rxAddrPass; // R22
            if (promiscuousEnable) begin
                // Sniffer: bad checksums still reported
                next_frameEnd = 1'b1; // R1
            end else begin
                next_frameEnd = rxAddrPass && rxFcsOk;
            end
            next_ackWanted = rxAddrPass && rxFcsOk &&
                rxAckRequest && ackAllowed; // R14
        end
    end

    // ============================================================
    // Event pulses and checksum status
    always @(posedge clk_sys) begin
        if (rst) begin
            rxStartEvent <= 1'b0;
            frameEndEvent <= 1'b0;
            addressMatchEvent <= 1'b0;
            crcValid <= 1'b0;
        end else begin
            rxStartEvent <= rxFrameStart; // R1
            frameEndEvent <= rxFrameDone && next_frameEnd; // R18
            addressMatchEvent <= rxFrameDone && next_addrMatch; // R22
            if (rxFrameDone) begin
                crcValid <= rxFcsOk; // R2
            end
        end
    end

    // ============================================================
    // Sleep/transmit pin edges
    reg pinLast;
    wire pinRise;
    wire pinFall;

    always @(posedge clk_sys) begin
        if (rst) begin
            pinLast <= 1'b0;
        end else begin
            pinLast <= sleepTransmitPin;
        end
    end

    assign pinRise = sleepTransmitPin && !pinLast;
    assign pinFall = !sleepTransmitPin && pinLast;

    // ============================================================
    // Acknowledgement timing
    wire ackLaunch;
    wire timerActive;

    assign ackLaunch = rxFrameDone && next_ackWanted;

    aar_ack_timer aar_ack_timer_inst (
        .clk_sys(clk_sys),
        .rst(rst),
        .start(ackLaunch),
        .shortDelay(ackDelaySelect),
        .slotted(slottedOp),
        .symbolTick(symbolTick),
        .trigger(pinRise), // R23
        .ackGo(ackTxStart),
        .waitTrigger(ackWaitTrigger),
        .active(timerActive)
    );

    // ============================================================
    // Receive state and clock output
    localparam [1:0] ST_LISTEN = 2'b00;
    localparam [1:0] ST_NOCLK = 2'b01;
    localparam [1:0] ST_BUSY = 2'b10;
    reg [1:0] next_trxState;
    reg [5:0] clkOffCount;
    wire validFrame;

    assign validFrame = rxFrameDone && rxAddrPass && rxFcsOk &&
        next_frameEnd;

    always @* begin
        next_trxState = trxState;
        case (trxState)
            ST_LISTEN: begin
                if (ackLaunch) begin
                    next_trxState = ST_BUSY; // R19
                end else if (pinRise) begin
                    next_trxState = ST_NOCLK; // R15
                end
            end
            ST_NOCLK: begin
                if (validFrame && ackLaunch) begin
                    next_trxState = ST_BUSY; // R19
                end else if (validFrame || pinFall) begin
                    next_trxState = ST_LISTEN; // R16
                end
            end
            ST_BUSY: begin
                // Pin edges here trigger slotted acks, not state changes
                if (ackTxDone && !timerActive) begin
                    next_trxState = ST_LISTEN; // R19
                end
            end
            default: begin
                next_trxState = ST_LISTEN;
            end
        endcase
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            trxState <= ST_LISTEN;
            clkOffCount <= 6'h00;
            hostClockOutEn <= 1'b1;
        end else begin
            trxState <= next_trxState; // R20
            if (next_trxState != ST_NOCLK) begin
                clkOffCount <= 6'h00;
                hostClockOutEn <= 1'b1; // R18
            end else if (trxState != ST_NOCLK) begin
                clkOffCount <= 6'h01;
                // Slow clocks stop at once; no grace for the host
                hostClockOutEn <= !clkRateSlow; // R17
            end else if (clkOffCount >= `AAR_CLK_OFF_CYCLES) begin
                hostClockOutEn <= 1'b0; // R17
            end else begin
                clkOffCount <= clkOffCount + 6'h01; // R17
            end
        end
    end

endmodule

// ===== test/aar_host_model.sv
// Purpose: Host controller model: register port and sleep/transmit pin.
// Assumes: Requests launch just after a rising edge.
// Notes: Read data is taken one edge after the address is presented.
`timescale 1ns/10ps
module aar_host_model (
    input wire clk_sys,
    input wire [7:0] regRdData,
    output logic [5:0] regAddr,
    output logic regWrEn,
    output logic [7:0] regWrData,
    output logic sleepTransmitPin
);
    initial begin
        regAddr = 6'h00;
        regWrEn = 1'h0;
        regWrData = 8'h00;
        sleepTransmitPin = 1'h0;
    end
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWrEn <= 1'h1;
        regWrData <= d;
        @(posedge clk_sys);
        regWrEn <= 1'h0;
        // Stale data would hide a missed strobe
        regWrData <= ~d;
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        @(posedge clk_sys);
        @(negedge clk_sys);
        d = regRdData;
    endtask
    task automatic pin(input logic v);
        @(posedge clk_sys);
        sleepTransmitPin <= v;
    endtask
endmodule

// ===== test/aar_receive_ctrl_chk.sv
// Purpose: Port-level checks for aar_receive_ctrl.
// Assumes: One clock, synchronous active-high reset.
// Notes: Clock-off delay is checked with a margin of three cycles early and one late.
`timescale 1ns/10ps
module aar_receive_ctrl_chk (
    input wire clk_sys,
    input wire rst,
    input wire [5:0] regAddr,
    input wire [7:0] regRdData,
    input wire sleepTransmitPin,
    input wire rxFrameStart,
    input wire rxFrameDone,
    input wire [2:0] rxFrameType,
    input wire rxFcsOk,
    input wire rxAddrPass,
    input wire clkRateSlow,
    input wire ackTxDone,
    input wire rxStartEvent,
    input wire frameEndEvent,
    input wire addressMatchEvent,
    input wire ackTxStart,
    input wire ackWaitTrigger,
    input wire hostClockOutEn,
    input wire [1:0] trxState,
    input wire promiscuousEnable
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // ============================================================
    // Cycles spent in the clockless state
    logic [5:0] offCnt;
    always_ff @(posedge clk_sys) begin
        if (rst || trxState != 2'h1)
            offCnt <= 6'h00;
        else if (offCnt != 6'h3F)
            offCnt <= offCnt + 6'h01;
    end
    // ============================================================
    // Assertions
    AST_RX_START: assert property (rxFrameStart |=> rxStartEvent)
        else $error("receive-start event missing");
    AST_PROM_END: assert property (rxFrameDone && promiscuousEnable
        && !rxFrameType[2] |=> frameEndEvent)
        else $error("sniffer frame without frame-end");
    AST_CRC_BIT: assert property (rxFrameDone ##1 regAddr == 6'h06
        |=> regRdData[7] == $past(rxFcsOk, 2))
        else $error("checksum-valid bit not updated");
    AST_RES_BAD: assert property (rxFrameDone && rxFrameType[2]
        && !rxFcsOk && !promiscuousEnable |=> !frameEndEvent)
        else $error("corrupted reserved frame reported");
    AST_NO_MATCH: assert property (rxFrameDone && !rxAddrPass
        |=> !addressMatchEvent)
        else $error("address match without filter pass");
    AST_ENTER: assert property (trxState == 2'h0
        && $rose(sleepTransmitPin) && !rxFrameDone |=> trxState == 2'h1)
        else $error("pin rise did not enter clockless state");
    AST_FALL_EXIT: assert property (trxState == 2'h1
        && $fell(sleepTransmitPin) && !rxFrameDone |=> trxState == 2'h0)
        else $error("pin fall did not leave clockless state");
    AST_VALID_EXIT: assert property (trxState == 2'h1 && rxFrameDone
        && rxAddrPass && rxFcsOk && !rxFrameType[2]
        |=> frameEndEvent && hostClockOutEn && trxState != 2'h1)
        else $error("valid frame did not restore clock");
    AST_CLK_HOLD: assert property (trxState == 2'h1 && !clkRateSlow
        && offCnt < 6'h20 |-> hostClockOutEn)
        else $error("clock output stopped too early");
    AST_CLK_OFF: assert property (trxState == 2'h1
        && offCnt > 6'h23 |-> !hostClockOutEn)
        else $error("clock output still running");
    AST_SLOW_OFF: assert property ($rose(trxState == 2'h1)
        && clkRateSlow |-> ##[0:1] !hostClockOutEn)
        else $error("slow clock output not stopped at once");
    AST_SLOT_GO: assert property (ackWaitTrigger
        && $rose(sleepTransmitPin) |-> ##[1:2] ackTxStart)
        else $error("slotted ack not started by pin");
    AST_BUSY_DONE: assert property (trxState == 2'h2 && ackTxDone
        |=> trxState == 2'h0)
        else $error("busy state not left after ack");
    cover property (ackWaitTrigger ##[1:20] ackTxStart);
    cover property (trxState == 2'h1 && !hostClockOutEn);
    cover property (rxFrameDone && rxFrameType[2] ##1 frameEndEvent);
endmodule

bind aar_receive_ctrl aar_receive_ctrl_chk aar_receive_ctrl_chk_inst (.*);

// ===== test/test_auto_ack_receive_extensions.sv
// Purpose: Directed test of aar_receive_ctrl through host model calls.
// Assumes: One symbol tick every four clock cycles.
// Notes: Frame inputs and ack completion come from the bench itself.
`timescale 1ns/10ps
module test_auto_ack_receive_extensions;
    logic clk_sys, rst, regWrEn, sleepTransmitPin, rxFrameStart;
    logic rxFrameDone, rxAckRequest, rxFcsOk, rxAddrPass, symbolTick;
    logic clkRateSlow, ackTxDone, rxStartEvent, frameEndEvent;
    logic addressMatchEvent, ackTxStart, ackWaitTrigger, hostClockOutEn;
    logic promiscuousEnable, frameProtectEn, coordinatorRole;
    logic [5:0] regAddr;
    logic [7:0] regWrData, regRdData, d;
    logic [2:0] rxFrameType;
    logic [1:0] rxFrameVersion, trxState, tickDiv;
    logic [5:0] ofs [4] = '{6'h0C, 6'h17, 6'h2C, 6'h2E};
    int badCount = 0, nTests = 0, i, p, v;
    aar_receive_ctrl aar_receive_ctrl_inst (.*);
    aar_host_model aar_host_model_inst (.*);
    initial begin
        clk_sys = 1'h0;
        forever #4 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (rst) begin
            tickDiv <= 2'h0;
            symbolTick <= 1'h0;
        end else begin
            tickDiv <= tickDiv + 2'h1;
            symbolTick <= (tickDiv == 2'h3);
        end
    end
    // ============================================================
    // Shared tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        nTests++;
        if (got !== exp) begin
            badCount++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrapUp;
        $display("comparisons=%0d mismatches=%0d", nTests, badCount);
        if (badCount == 0 && nTests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ev packs {state, frame-end, address-match}
    task automatic frm(input logic [2:0] ty, input logic [1:0] ver,
            input logic ak, fc, ad, input logic [7:0] ev);
        @(posedge clk_sys);
        rxFrameStart <= 1'h1;
        @(posedge clk_sys);
        rxFrameStart <= 1'h0;
        rxFrameDone <= 1'h1;
        rxFrameType <= ty;
        rxFrameVersion <= ver;
        rxAckRequest <= ak;
        rxFcsOk <= fc;
        rxAddrPass <= ad;
        @(negedge clk_sys);
        chk({7'h00, rxStartEvent}, 8'h01);
        @(posedge clk_sys);
        rxFrameDone <= 1'h0;
        rxFcsOk <= ~fc;
        rxAddrPass <= ~ad;
        @(negedge clk_sys);
        chk({4'h0, trxState, frameEndEvent, addressMatchEvent}, ev);
    endtask
    task automatic ackWait(input logic [7:0] n, input logic slot);
        logic [7:0] ticks;
        int k;
        ticks = 8'h00;
        for (k = 0; k < 400 && !(slot ? ackWaitTrigger : ackTxStart);
                k++) begin
            if (symbolTick)
                ticks++;
            @(negedge clk_sys);
        end
        if (k == 400) begin
            badCount++;
            wrapUp();
        end
        chk(ticks, n);
        if (slot) begin
            aar_host_model_inst.pin(1'h1);
            for (k = 0; k < 4 && !ackTxStart; k++)
                @(negedge clk_sys);
            chk({7'h00, ackTxStart}, 8'h01);
            aar_host_model_inst.pin(1'h0);
        end
        @(posedge clk_sys);
        ackTxDone <= 1'h1;
        @(posedge clk_sys);
        ackTxDone <= 1'h0;
        @(negedge clk_sys);
        chk({6'h00, trxState}, 8'h00);
    endtask
    task automatic pinState(input logic v, input logic [7:0] st);
        aar_host_model_inst.pin(v);
        repeat (2) @(negedge clk_sys);
        chk({6'h00, trxState}, st);
    endtask
    // ============================================================
    // Main sequence
    initial begin
        rst = 1'h1;
        {rxFrameStart, rxFrameDone, rxAckRequest, rxFcsOk} = 4'h0;
        {rxAddrPass, clkRateSlow, ackTxDone} = 3'h0;
        rxFrameType = 3'h0;
        rxFrameVersion = 2'h0;
        repeat (5) @(posedge clk_sys);
        rst <= 1'h0;
        chk({7'h00, hostClockOutEn}, 8'h01);
        for (i = 0; i < 4; i++) begin
            aar_host_model_inst.rd(ofs[i], d);
            chk(d, 8'h00);
            aar_host_model_inst.wr(ofs[i], 8'hFF);
            aar_host_model_inst.rd(ofs[i], d);
            chk(d, 8'hFF);
        end
        chk({5'h00, promiscuousEnable, frameProtectEn, coordinatorRole},
            8'h07);
        aar_host_model_inst.wr(6'h06, 8'hFF);
        aar_host_model_inst.rd(6'h06, d);
        chk(d, 8'h00);
        aar_host_model_inst.rd(6'h3F, d);
        chk(d, 8'h00);
        for (i = 0; i < 4; i++)
            aar_host_model_inst.wr(ofs[i], 8'h00);
        // Sniffer setup
        aar_host_model_inst.wr(6'h17, 8'h02);
        aar_host_model_inst.wr(6'h2E, 8'h10);
        aar_host_model_inst.rd(6'h06, d);
        frm(3'h1, 2'h0, 1'h1, 1'h0, 1'h0, 8'h02);
        aar_host_model_inst.rd(6'h06, d);
        chk(d, 8'h00);
        frm(3'h1, 2'h0, 1'h1, 1'h1, 1'h1, 8'h03);
        aar_host_model_inst.rd(6'h06, d);
        chk(d, 8'h80);
        // Reserved frame types
        aar_host_model_inst.wr(6'h2E, 8'h00);
        aar_host_model_inst.wr(6'h17, 8'h00);
        frm(3'h4, 2'h0, 1'h1, 1'h1, 1'h1, 8'h00);
        aar_host_model_inst.wr(6'h17, 8'h10);
        frm(3'h4, 2'h0, 1'h1, 1'h1, 1'h0, 8'h02);
        frm(3'h4, 2'h0, 1'h1, 1'h0, 1'h1, 8'h00);
        aar_host_model_inst.wr(6'h17, 8'h30);
        frm(3'h4, 2'h0, 1'h1, 1'h1, 1'h1, 8'h0B);
        ackWait(8'h0C, 1'h0);
        frm(3'h4, 2'h0, 1'h1, 1'h1, 1'h0, 8'h00);
        // Version policy with short ack timing
        aar_host_model_inst.wr(6'h17, 8'h04);
        for (p = 0; p < 4; p++) begin
            aar_host_model_inst.wr(6'h2E, 8'(p << 6));
            for (v = 0; v < 4; v++) begin
                frm(3'h1, 2'(v), 1'h1, 1'h1, 1'h1,
                    (p == 3 || v <= p) ? 8'h0B : 8'h03);
                if (p == 3 || v <= p)
                    ackWait(8'h02, 1'h0);
            end
        end
        aar_host_model_inst.wr(6'h2E, 8'h00);
        // Slotted acknowledgement
        aar_host_model_inst.wr(6'h2C, 8'h01);
        frm(3'h1, 2'h0, 1'h1, 1'h1, 1'h1, 8'h0B);
        ackWait(8'h06, 1'h1);
        aar_host_model_inst.wr(6'h2C, 8'h00);
        // Clockless listening
        aar_host_model_inst.pin(1'h1);
        for (i = 0; i < 60 && hostClockOutEn; i++)
            @(negedge clk_sys);
        chk({7'h00, i >= 33 && i <= 37}, 8'h01);
        chk({6'h00, trxState}, 8'h01);
        frm(3'h1, 2'h0, 1'h0, 1'h1, 1'h1, 8'h03);
        chk({7'h00, hostClockOutEn}, 8'h01);
        repeat (5) @(negedge clk_sys);
        chk({6'h00, trxState}, 8'h00);
        aar_host_model_inst.pin(1'h0);
        pinState(1'h1, 8'h01);
        frm(3'h1, 2'h0, 1'h1, 1'h1, 1'h1, 8'h0B);
        ackWait(8'h02, 1'h0);
        aar_host_model_inst.pin(1'h0);
        pinState(1'h1, 8'h01);
        pinState(1'h0, 8'h00);
        @(posedge clk_sys);
        clkRateSlow <= 1'h1;
        pinState(1'h1, 8'h01);
        chk({7'h00, hostClockOutEn}, 8'h00);
        pinState(1'h0, 8'h00);
        wrapUp();
    end
endmodule
